// ---- shared/pfci_cfg.svh ----
// Timing counts, command codes and address constants for the flash host
`ifndef PFCI_CFG_SVH
`define PFCI_CFG_SVH
`define PFCI_CMD_ERASE_SETUP 8'h20
`define PFCI_CMD_ERASE_EXEC 8'hD0
`define PFCI_CMD_PROG_SETUP 8'h10
`define PFCI_CMD_CHIP_ERASE 8'h30
`define PFCI_CMD_ABORT 8'hFF
`define PFCI_CMD_READ_ID 8'h90
`define PFCI_ID_MAKER_ADDR 19'h0_0000
`define PFCI_ID_DEVICE_ADDR 19'h0_0001
`define PFCI_LOCK_A0 19'h0_1823
`define PFCI_LOCK_A1 19'h0_1820
`define PFCI_LOCK_A2 19'h0_1822
`define PFCI_LOCK_A3 19'h0_0418
`define PFCI_LOCK_A4 19'h0_041B
`define PFCI_LOCK_A5 19'h0_0419
`define PFCI_UNLOCK_LAST 19'h0_041A
`define PFCI_LOCK_LAST 19'h0_040A
`define PFCI_SECTOR_LSB 8
`define PFCI_CLK_NS 50
`define PFCI_STROBE_NS 100
`define PFCI_SETUP_NS 50
`define PFCI_STROBE_CYC ((`PFCI_STROBE_NS + `PFCI_CLK_NS - 1) / `PFCI_CLK_NS)
`define PFCI_SETUP_CYC ((`PFCI_SETUP_NS + `PFCI_CLK_NS - 1) / `PFCI_CLK_NS)
`endif

// ---- shared/pfci_pkg.sv ----
// Types shared by the flash host controller
package pfci_pkg;
    typedef enum logic [2:0] {
        PFCI_OP_READ,
        PFCI_OP_PROGRAM,
        PFCI_OP_SECTOR_ERASE,
        PFCI_OP_CHIP_ERASE,
        PFCI_OP_ABORT,
        PFCI_OP_READ_ID,
        PFCI_OP_LOCK,
        PFCI_OP_UNLOCK
    } pfci_op_t;

    typedef struct packed {
        pfci_op_t op;
        logic [18:0] addr;
        logic [7:0] data;
    } pfci_req_t;

    typedef struct packed {
        logic cs_n;
        logic oe_n;
        logic we_n;
        logic [18:0] addr;
        logic [7:0] dout;
        logic dq_oe;
    } pfci_pins_t;
endpackage

// ---- hw/pfci_cycle.sv ----
// One strobe bus cycle (read or write) on the flash pins
`timescale 1ns/10ps
`include "pfci_cfg.svh"
module pfci_cycle (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Cycle request
    input wire logic start_i,
    input wire logic is_write_i,
    input wire logic [18:0] addr_i,
    input wire logic [7:0] data_i,
    input wire logic [7:0] dq_sync_i,
    output logic done_o,
    output logic [7:0] rdata_o,
    // Pins
    output pfci_pkg::pfci_pins_t pins_o
);
    import pfci_pkg::*;
    localparam int TOTAL = `PFCI_SETUP_CYC + `PFCI_STROBE_CYC + 1;
    logic [3:0] cnt_ff;
    logic busy_ff;
    logic wr_ff;

    // Phase counter: setup, strobe low, release
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_ff <= 1'b0;
            cnt_ff <= 4'h0;
            wr_ff <= 1'b0;
        end else if (start_i && !busy_ff) begin
            busy_ff <= 1'b1;
            cnt_ff <= 4'h0;
            wr_ff <= is_write_i;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == 4'(TOTAL)) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // Pin drive; address held valid through the whole cycle
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pins_o <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                        addr: 19'h0_0000, dout: 8'h00, dq_oe: 1'b0};
            done_o <= 1'b0;
            rdata_o <= 8'h00;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_ff) begin
                // R17 valid address level
                pins_o.addr <= addr_i;
                pins_o.dout <= data_i;
                pins_o.cs_n <= 1'b0;
                // R7 oe high on write
                pins_o.oe_n <= 1'b1;
                pins_o.dq_oe <= is_write_i;
            end else if (busy_ff) begin
                if (cnt_ff == 4'(`PFCI_SETUP_CYC - 1)) begin
                    // R14 reads are real reads
                    if (wr_ff) pins_o.we_n <= 1'b0;
                    else pins_o.oe_n <= 1'b0;
                end
                if (cnt_ff == 4'(`PFCI_SETUP_CYC + `PFCI_STROBE_CYC - 1)) begin
                    // R21 data held past rising edge
                    pins_o.we_n <= 1'b1;
                    pins_o.oe_n <= 1'b1;
                end
                if (cnt_ff == 4'(TOTAL - 1)) begin
                    pins_o.cs_n <= 1'b1;
                end
                if (cnt_ff == 4'(TOTAL)) begin
                    pins_o.dq_oe <= 1'b0;
                    done_o <= 1'b1;
                    // Synced data lags the pin by two edges, so this takes
                    // the pin as it stood while the output gate was low
                    if (!wr_ff) rdata_o <= dq_sync_i;
                end
            end
        end
    end
endmodule

// ---- hw/pfci_host.sv ----
// Host controller sequencing commands onto a byte-wide parallel flash
// Notes on behaviour
// R1 - Address bits 18..8 pick a 256 byte sector.
// R2 - Address bits 7..0 pick the byte within the sector.
// R3 - Device drives reads, takes write data and latches it.
// R4 - Device floats data when output gate or select is high; the model drives the inverted last byte instead.
// R5 - Device answers only with select low; otherwise standby.
// R6 - Output gate decides whether device drives data during reads.
// R7 - Each write is a write strobe pulse, select low, gate high.
// R8 - Sector erase: write 20H, then D0H at the sector address.
// R9 - Program: write 10H, then the byte at its full address.
// R10 - Chip erase: two writes of 30H; absent on one variant.
// R11 - Abort FFH and identify 90H work even when locked.
// R12 - Locked device refuses erase and program sequences.
// R13 - After identify, addresses 0 and 1 give maker and device.
// R14 - Lock set and clear only by seven consecutive reads.
// R15 - Identify also reachable by raised address bit 9.
// R16 - Both identify methods give the same codes.
// R17 - Cycles are reads or writes; setup address merely valid.
// R18 - Unlock reads 1823,1820,1822,0418,041B,0419,041A in order.
// R19 - Lock uses the same reads ending at 040A.
// R20 - Device powers up in read mode and locked.
// R21 - Program address taken at later fall, data at earlier rise.
// R22 - Mismatched execute write cancels setup without array change.
`timescale 1ns/10ps
`include "pfci_cfg.svh"
module pfci_host #(
    parameter bit CHIP_ERASE_EN = 1'b1
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Request port
    input wire pfci_pkg::pfci_req_t req_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    output logic done_o,
    output logic refused_o,
    output logic [7:0] rdata_o,
    output logic [7:0] id_maker_o,
    output logic [7:0] id_device_o,
    // Flash pins
    output logic cs_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic [18:0] addr_o,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    output logic dq_oe_o
);
    import pfci_pkg::*;

    typedef enum {
        PFCI_IDLE, PFCI_ISSUE, PFCI_WAIT, PFCI_DONE
    } pfci_state_t;

    logic rst_meta_ff, rst_n_ff;
    logic [7:0] dq_meta_ff, dq_sync_ff;
    pfci_state_t state_ff;
    pfci_req_t cur_ff;
    logic [2:0] step_ff;
    logic [2:0] last_step;
    logic cyc_start_ff;
    logic cyc_done;
    logic [7:0] cyc_rdata;
    pfci_pins_t pins;
    logic cyc_write;
    logic [18:0] cyc_addr;
    logic [7:0] cyc_data;

    // Reset release synchroniser
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // Data pins cross in through two flops
    always_ff @(posedge mclk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            dq_meta_ff <= 8'h00;
            dq_sync_ff <= 8'h00;
        end else begin
            dq_meta_ff <= dq_i;
            dq_sync_ff <= dq_meta_ff;
        end
    end

    // Address of lock read number idx
    function automatic logic [18:0] lock_addr(input logic [2:0] idx,
                                              input logic set);
        case (idx)
            3'd0: lock_addr = `PFCI_LOCK_A0;
            3'd1: lock_addr = `PFCI_LOCK_A1;
            3'd2: lock_addr = `PFCI_LOCK_A2;
            3'd3: lock_addr = `PFCI_LOCK_A3;
            3'd4: lock_addr = `PFCI_LOCK_A4;
            3'd5: lock_addr = `PFCI_LOCK_A5;
            default: lock_addr = set ? `PFCI_LOCK_LAST : `PFCI_UNLOCK_LAST;
        endcase
    endfunction

    // Number of bus cycles in each operation, less one
    always_comb begin
        case (cur_ff.op)
            PFCI_OP_READ: last_step = 3'd0;
            PFCI_OP_ABORT: last_step = 3'd0;
            // R13 identify then two id reads
            PFCI_OP_READ_ID: last_step = 3'd2;
            // R14 seven consecutive reads
            PFCI_OP_LOCK: last_step = 3'd6;
            PFCI_OP_UNLOCK: last_step = 3'd6;
            default: last_step = 3'd1;
        endcase
    end

    // Cycle kind, address and data for the current step
    always_comb begin
        cyc_write = 1'b1;
        // R17 setup address don't care
        cyc_addr = 19'h0_0000;
        cyc_data = 8'h00;
        case (cur_ff.op)
            PFCI_OP_READ: begin
                cyc_write = 1'b0;
                cyc_addr = cur_ff.addr;
            end
            PFCI_OP_PROGRAM: begin
                // R9 setup then full address byte
                cyc_data = (step_ff == 3'd0) ? `PFCI_CMD_PROG_SETUP
                                             : cur_ff.data;
                if (step_ff != 3'd0) cyc_addr = cur_ff.addr;
            end
            PFCI_OP_SECTOR_ERASE: begin
                // R8 erase at sector address
                cyc_data = (step_ff == 3'd0) ? `PFCI_CMD_ERASE_SETUP
                                             : `PFCI_CMD_ERASE_EXEC;
                // R1 sector field, R2 byte bits zero
                if (step_ff != 3'd0) begin
                    cyc_addr = {cur_ff.addr[18:`PFCI_SECTOR_LSB], 8'h00};
                end
            end
            // R10 two chip erase writes
            PFCI_OP_CHIP_ERASE: cyc_data = `PFCI_CMD_CHIP_ERASE;
            // R11 single abort write
            PFCI_OP_ABORT: cyc_data = `PFCI_CMD_ABORT;
            PFCI_OP_READ_ID: begin
                if (step_ff == 3'd0) begin
                    cyc_data = `PFCI_CMD_READ_ID;
                end else begin
                    cyc_write = 1'b0;
                    cyc_addr = (step_ff == 3'd1) ? `PFCI_ID_MAKER_ADDR
                                                 : `PFCI_ID_DEVICE_ADDR;
                end
            end
            default: begin
                // R18 R19 lock address sequence
                cyc_write = 1'b0;
                cyc_addr = lock_addr(step_ff, cur_ff.op == PFCI_OP_LOCK);
            end
        endcase
    end

    // Operation sequencer
    always_ff @(posedge mclk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff <= PFCI_IDLE;
            cur_ff <= '0;
            step_ff <= 3'd0;
            cyc_start_ff <= 1'b0;
            req_ready_o <= 1'b0;
            done_o <= 1'b0;
            refused_o <= 1'b0;
        end else begin
            cyc_start_ff <= 1'b0;
            done_o <= 1'b0;
            refused_o <= 1'b0;
            case (state_ff)
                PFCI_IDLE: begin
                    req_ready_o <= 1'b1;
                    if (req_valid_i && req_ready_o) begin
                        req_ready_o <= 1'b0;
                        cur_ff <= req_i;
                        step_ff <= 3'd0;
                        if (req_i.op == PFCI_OP_CHIP_ERASE &&
                            !CHIP_ERASE_EN) begin
                            // Refusal is flagged in the done state
                            state_ff <= PFCI_DONE;
                        end else begin
                            state_ff <= PFCI_ISSUE;
                        end
                    end
                end
                PFCI_ISSUE: begin
                    cyc_start_ff <= 1'b1;
                    state_ff <= PFCI_WAIT;
                end
                PFCI_WAIT: begin
                    if (cyc_done) begin
                        if (step_ff == last_step) begin
                            state_ff <= PFCI_DONE;
                        end else begin
                            step_ff <= step_ff + 3'd1;
                            state_ff <= PFCI_ISSUE;
                        end
                    end
                end
                default: begin
                    done_o <= 1'b1;
                    // R10 refusal pulses together with done
                    refused_o <= !CHIP_ERASE_EN &&
                                 (cur_ff.op == PFCI_OP_CHIP_ERASE);
                    state_ff <= PFCI_IDLE;
                end
            endcase
        end
    end

    // Read data and identification capture
    always_ff @(posedge mclk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rdata_o <= 8'h00;
            id_maker_o <= 8'h00;
            id_device_o <= 8'h00;
        end else if (state_ff == PFCI_WAIT && cyc_done && !cyc_write) begin
            rdata_o <= cyc_rdata;
            if (cur_ff.op == PFCI_OP_READ_ID) begin
                if (step_ff == 3'd1) id_maker_o <= cyc_rdata;
                else id_device_o <= cyc_rdata;
            end
        end
    end

    // Registered pin outputs
    always_ff @(posedge mclk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cs_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            we_n_o <= 1'b1;
            addr_o <= 19'h0_0000;
            dq_o <= 8'h00;
            dq_oe_o <= 1'b0;
        end else begin
            cs_n_o <= pins.cs_n;
            oe_n_o <= pins.oe_n;
            we_n_o <= pins.we_n;
            addr_o <= pins.addr;
            dq_o <= pins.dout;
            dq_oe_o <= pins.dq_oe;
        end
    end

    pfci_cycle u_cycle (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_ff),
        .start_i(cyc_start_ff),
        .is_write_i(cyc_write),
        .addr_i(cyc_addr),
        .data_i(cyc_data),
        .dq_sync_i(dq_sync_ff),
        .done_o(cyc_done),
        .rdata_o(cyc_rdata),
        .pins_o(pins)
    );
endmodule

// ---- test/pfci_flash_model.sv ----
// Behavioural byte-wide flash device answering the host's pins
`timescale 1ns/10ps
module pfci_flash_model #(
    parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
    parameter logic [7:0] DEV_ID = 8'hC3 // Arbitrary value
) (
    // Pins from the host
    input wire logic cs_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic [18:0] addr_i,
    input wire logic [7:0] dq_i,
    // Data back to the host
    output logic [7:0] dq_o
);
    localparam logic [18:0] SEQ [6] = '{19'h0_1823, 19'h0_1820,
        19'h0_1822, 19'h0_0418, 19'h0_041B, 19'h0_0419};
    logic [7:0] mem [logic [18:0]];
    logic [2:0] mode = 3'h0; // 0 read, 1 erase, 2 program, 3 chip, 4 ident
    logic locked = 1'b1;
    logic [2:0] seq = 3'h0;
    logic [18:0] wa = '0;
    logic [7:0] last = 8'h00;
    // drive read data while selected and gated, else the inverted last byte
    always @(cs_n_i, oe_n_i, addr_i, mode) begin
        if (!cs_n_i && !oe_n_i) begin
            // software route; the raised address pin is electrical only
            if (mode == 3'h4) begin
                last = addr_i[0] ? DEV_ID : MAKER_ID;
            end else begin
                last = mem.exists(addr_i) ? mem[addr_i] : 8'hFF;
            end
            dq_o = last;
        end else begin
            dq_o = ~last; // Released bus shows no stale value
        end
    end
    // seven-read lock sequence, address at gate rise
    always @(posedge oe_n_i) begin
        if (!cs_n_i && seq == 3'h6) begin
            if (addr_i == 19'h0_041A) locked = 1'b0;
            if (addr_i == 19'h0_040A) locked = 1'b1;
            seq = 3'h0;
        end else if (!cs_n_i) begin
            if (addr_i == SEQ[seq]) seq = seq + 3'h1;
            else seq = (addr_i == SEQ[0]) ? 3'h1 : 3'h0;
        end
    end
    // address on the later falling edge
    always @(negedge we_n_i) begin
        if (!cs_n_i) wa = addr_i;
    end
    always @(posedge we_n_i) begin
        if (!cs_n_i && oe_n_i) begin
            seq = 3'h0;
            case (mode)
                3'h2: if (!locked) mem[wa] = dq_i;
                3'h1: if (!locked && dq_i == 8'hD0) begin
                    for (int i = 0; i < 256; i++) begin
                        mem[{wa[18:8], i[7:0]}] = 8'hFF;
                    end
                end
                3'h3: if (!locked && dq_i == 8'h30) mem.delete();
                default: ;
            endcase
            if (mode != 3'h0 && mode != 3'h4) mode = 3'h0;
            else if (dq_i == 8'h20) mode = 3'h1;
            else if (dq_i == 8'h10) mode = 3'h2;
            else if (dq_i == 8'h30) mode = 3'h3;
            else if (dq_i == 8'h90) mode = 3'h4;
            else mode = 3'h0;
        end
    end
endmodule

// ---- test/pfci_host_chk.sv ----
// Concurrent checks on the flash host controller's ports
`timescale 1ns/10ps
module pfci_host_chk (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Completion
    input wire logic done_o,
    input wire logic refused_o,
    // Flash pins
    input wire logic cs_n_o,
    input wire logic oe_n_o,
    input wire logic we_n_o,
    input wire logic [18:0] addr_o,
    input wire logic [7:0] dq_o,
    input wire logic dq_oe_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);
    chk_write_qual: assert property (
        !we_n_o |-> !cs_n_o && oe_n_o && dq_oe_o)
        else $error("write strobe without select or with gate low");
    chk_read_gate: assert property (
        !oe_n_o |-> !cs_n_o && we_n_o && !dq_oe_o)
        else $error("host drives data or strobes during a read");
    chk_we_width: assert property (
        $fell(we_n_o) |-> !we_n_o [*2] ##1 we_n_o)
        else $error("write strobe width wrong");
    chk_data_hold: assert property (
        $rose(we_n_o) |-> dq_oe_o && $stable(dq_o))
        else $error("write data not held across strobe rise");
    chk_addr_hold: assert property (
        !cs_n_o && !$past(cs_n_o) |-> $stable(addr_o))
        else $error("address moved inside a bus cycle");
    chk_cs_release: assert property (
        $rose(cs_n_o) |-> $past(we_n_o) && $past(oe_n_o))
        else $error("select rose before the strobes");
    chk_idle_float: assert property (
        cs_n_o && $past(cs_n_o) |-> !dq_oe_o && we_n_o && oe_n_o)
        else $error("activity on pins while deselected");
    chk_refuse_pins: assert property (
        refused_o |-> done_o && cs_n_o ##1 !done_o)
        else $error("refusal without done or with select low");
endmodule
bind pfci_host pfci_host_chk i_pfci_host_chk (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .done_o(done_o),
    .refused_o(refused_o),
    .cs_n_o(cs_n_o),
    .oe_n_o(oe_n_o),
    .we_n_o(we_n_o),
    .addr_o(addr_o),
    .dq_o(dq_o),
    .dq_oe_o(dq_oe_o)
);

// ---- test/pfci_host_tb_top.sv ----
// Self-checking bench for the flash host controller with a device model
`timescale 1ns/10ps
module pfci_host_tb_top;
    import pfci_pkg::*;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    pfci_req_t req_i = '0;
    logic req_valid_i = 1'b0;
    logic req_ready_o, done_o, refused_o, cs_n_o, oe_n_o, we_n_o, dq_oe_o;
    logic [7:0] rdata_o, id_maker_o, id_device_o, dq_o, dev_dq, bus_dq;
    logic [18:0] addr_o;
    logic req_valid_ne = 1'b0;
    logic req_ready_ne, done_ne, refused_ne, cs_n_ne;
    int mismatches = 0;
    int comparisons = 0;
    // Clock and shared data wire
    always #25 mclk_i = ~mclk_i;
    assign bus_dq = dq_oe_o ? dq_o : dev_dq;
    pfci_host i_pfci_host (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .req_i(req_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .done_o(done_o), .refused_o(refused_o), .rdata_o(rdata_o),
        .id_maker_o(id_maker_o), .id_device_o(id_device_o),
        .cs_n_o(cs_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
        .addr_o(addr_o), .dq_i(bus_dq), .dq_o(dq_o), .dq_oe_o(dq_oe_o)
    );
    // Second host without chip erase, to show its refusal
    pfci_host #(.CHIP_ERASE_EN(1'b0)) i_pfci_host_noerase (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .req_i(req_i),
        .req_valid_i(req_valid_ne), .req_ready_o(req_ready_ne),
        .done_o(done_ne), .refused_o(refused_ne), .rdata_o(),
        .id_maker_o(), .id_device_o(), .cs_n_o(cs_n_ne), .oe_n_o(),
        .we_n_o(), .addr_o(), .dq_i(8'h00), .dq_o(), .dq_oe_o()
    );
    pfci_flash_model i_pfci_flash_model (
        .cs_n_i(cs_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
        .addr_i(addr_o), .dq_i(bus_dq), .dq_o(dev_dq)
    );
    task automatic end_of_test;
        if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Issue one request and wait for its completion pulse
    task automatic op(input pfci_op_t o, input logic [18:0] a,
                      input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 300) begin
            @(posedge mclk_i);
            #2;
            n++;
        end
        req_i = '{op: o, addr: a, data: d};
        req_valid_i = 1'b1;
        @(posedge mclk_i);
        #2;
        req_valid_i = 1'b0;
        while (done_o !== 1'b1 && n < 300) begin
            @(posedge mclk_i);
            #2;
            n++;
        end
        if (n >= 300) begin
            mismatches++;
            end_of_test();
        end
        @(posedge mclk_i);
        #2;
    endtask
    task automatic rd(input logic [18:0] a, input logic [7:0] exp);
        op(PFCI_OP_READ, a, 8'h00);
        check(rdata_o, exp);
    endtask
    task automatic t_locked;
        op(PFCI_OP_PROGRAM, 19'h1_2345, 8'h3C);
        rd(19'h1_2345, 8'hFF);
    endtask
    task automatic t_ident;
        op(PFCI_OP_READ_ID, 19'h0_0000, 8'h00);
        check(id_maker_o, 8'h5A);
        check(id_device_o, 8'hC3);
        op(PFCI_OP_ABORT, 19'h0_0000, 8'h00);
        rd(19'h0_0000, 8'hFF);
    endtask
    task automatic t_unlock_prog;
        op(PFCI_OP_UNLOCK, 19'h0_0000, 8'h00);
        op(PFCI_OP_PROGRAM, 19'h1_2345, 8'h3C);
        rd(19'h1_2345, 8'h3C);
        rd(19'h1_2344, 8'hFF);
    endtask
    task automatic t_sector;
        op(PFCI_OP_PROGRAM, 19'h1_23FF, 8'hA5);
        op(PFCI_OP_PROGRAM, 19'h1_2400, 8'h5A);
        op(PFCI_OP_SECTOR_ERASE, 19'h1_2377, 8'h00);
        rd(19'h1_2345, 8'hFF);
        rd(19'h1_23FF, 8'hFF);
        rd(19'h1_2400, 8'h5A);
    endtask
    task automatic t_chip;
        op(PFCI_OP_CHIP_ERASE, 19'h0_0000, 8'h00);
        rd(19'h1_2400, 8'hFF);
    endtask
    task automatic t_lock;
        op(PFCI_OP_PROGRAM, 19'h0_0010, 8'h77);
        op(PFCI_OP_LOCK, 19'h0_0000, 8'h00);
        op(PFCI_OP_PROGRAM, 19'h0_0010, 8'h11);
        op(PFCI_OP_SECTOR_ERASE, 19'h0_0000, 8'h00);
        rd(19'h0_0010, 8'h77);
    endtask
    // Chip erase on the variant without it is refused, pins left idle
    task automatic t_refuse;
        int n;
        n = 0;
        while (req_ready_ne !== 1'b1 && n < 50) begin
            @(posedge mclk_i);
            #2;
            n++;
        end
        req_i = '{op: PFCI_OP_CHIP_ERASE, addr: 19'h0_0000, data: 8'h00};
        req_valid_ne = 1'b1;
        @(posedge mclk_i);
        #2;
        req_valid_ne = 1'b0;
        while (done_ne !== 1'b1 && n < 50) begin
            @(posedge mclk_i);
            #2;
            n++;
        end
        if (n >= 50) begin
            mismatches++;
            end_of_test();
        end
        check({7'h00, refused_ne}, 8'h01);
        check({7'h00, cs_n_ne}, 8'h01);
    endtask
    // Reset for three cycles, then the scenarios
    initial begin
        repeat (3) @(posedge mclk_i);
        #2;
        nrst_i = 1'b1;
        t_locked();
        t_ident();
        t_unlock_prog();
        t_sector();
        t_chip();
        t_lock();
        t_refuse();
        end_of_test();
    end
endmodule
